// file: icsf_cfg.svh
// offsets, field positions, reset values and masks for the i2c control block
// assumes inclusion by bare name from the package; the design module uses its macros
`ifndef ICSF_CFG_SVH
`define ICSF_CFG_SVH
`define ICSF_OFF_CTRL 4'h0
`define ICSF_OFF_FRAME 4'h4
`define ICSF_OFF_EVENT 4'h8
`define ICSF_CTRL_RESET 16'h0000
`define ICSF_CTRL_MASK 16'hBFFB
`define ICSF_FRAME_RESET 16'h0000
`define ICSF_B_EN 0
`define ICSF_B_SMB 1
`define ICSF_B_HOST 3
`define ICSF_B_ARP 4
`define ICSF_B_CRC 5
`define ICSF_B_GC 6
`define ICSF_B_NOSTR 7
`define ICSF_B_START 8
`define ICSF_B_STOP 9
`define ICSF_B_ACK 10
`define ICSF_B_POS 11
`define ICSF_B_CRCSEND 12
`define ICSF_B_ALERT 13
`define ICSF_B_SRST 15
`define ICSF_F_MODE 0
`define ICSF_F_IE 1
`define ICSF_F_OLVL 8
`define ICSF_F_ILVL 9
`define ICSF_F_ORISE 10
`define ICSF_F_OFALL 11
`define ICSF_F_IRISE 12
`define ICSF_F_IFALL 13
`endif

// file: icsf_pkg.sv
// types shared by the i2c control block
// assumes the cfg header sits in the same folder
package icsf_pkg;
`include "icsf_cfg.svh"
   typedef struct packed {
      logic start_sent;
      logic addr_done;
      logic header_sent;
      logic stop_seen;
      logic byte_done;
      logic tx_empty;
      logic rx_full;
   } icsf_event_s;
   typedef struct packed {
      logic bus_error;
      logic arb_lost;
      logic over_under;
      logic no_ack;
      logic crc_mismatch;
      logic bus_timeout;
      logic alert;
   } icsf_error_s;
   typedef enum logic [1:0] {ICSF_IDLE, ICSF_ACK} icsf_bus_e;
endpackage : icsf_pkg

// file: icsf_ctrl.sv
// control, frame pin and status logic of a two-wire bus controller
// assumes a classic wishbone master on clk_i, and a transfer engine outside
// that reports events, errors and bus conditions as same-clock pulses/levels
// Notes on behaviour
// - master busy drives frame output pin
// - frame input shares the alert pin
// - frame mode only while mode enabled
// - edge flags and level flags per pin
// - frame interrupt only when enabled
// - event flags for transfer progress
// - error flags, over/under only without stretch
// - soft reset bit holds controller reset
// - alert bit drives alert pin low
// - crc send cleared after send, start/stop, disable
// - ack position bit cleared on disable
// - ack enable bit cleared on disable
// - stop set on timeout, cleared on stop
// - start cleared on start seen, disable
// - stretch disable bit for slave mode
// - general call response enable bit
// - crc calculation enable bit
// - address resolution enable in smbus mode
// - smbus role host or device
// - plain or smbus operation select
// - half-word and word access, reserved fixed
// - peripheral enable, disable clears bits
`timescale 1ns/10ps
module icsf_ctrl
   import icsf_pkg::*;
(
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   input wire logic master_busy_i,
   input wire logic master_mode_i,
   input wire icsf_event_s event_set_i,
   input wire icsf_event_s event_clr_i,
   input wire icsf_error_s error_set_i,
   input wire logic crc_done_i,
   input wire logic start_seen_i,
   input wire logic stop_seen_i,
   input wire logic alert_pin_i,
   output logic alert_pin_o,
   output logic alert_pin_oe_o,
   output logic frame_out_o,
   output logic frame_irq_o,
   output logic ctrl_reset_o,
   output logic periph_en_o,
   output logic smbus_mode_o,
   output logic host_select_o,
   output logic addr_res_en_o,
   output logic crc_en_o,
   output logic general_call_en_o,
   output logic stretch_dis_o,
   output logic start_req_o,
   output logic stop_req_o,
   output logic ack_en_o,
   output logic ack_pos_o,
   output logic crc_send_o
);
   logic [15:0] control_main;
   logic [15:0] next_ctrl;
   logic [15:0] frame_ctrl_status_reg;
   icsf_event_s ev_flags;
   icsf_error_s er_flags;
   icsf_bus_e bus_st;
   logic in_meta, in_sync, in_prev, out_prev;
   logic req, wr, soft_rst;
   logic [15:0] wmask;

   // wishbone request and lane mask; the mask covers the low half-word only
   assign req = wb_cyc_i && wb_stb_i && (bus_st == ICSF_IDLE);
   assign wr = req && wb_we_i;
   assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign soft_rst = control_main[`ICSF_B_SRST];

   // bus state: one ack cycle, then ack drops for one cycle
   // a request still standing in the ack cycle is not taken twice
   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         bus_st <= ICSF_IDLE;
      end
      else
      begin
         unique case (bus_st)
            ICSF_IDLE:
            begin
               if (wb_cyc_i && wb_stb_i)
               begin
                  bus_st <= ICSF_ACK;
               end
            end
            ICSF_ACK:
            begin
               bus_st <= ICSF_IDLE;
            end
         endcase
      end
   end

   // mapped offsets answer with ack, others with err
   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         if (req)
         begin
            wb_dat_o <= 32'h0000_0000;
            unique case (wb_adr_i)
               `ICSF_OFF_CTRL:
               begin
                  wb_ack_o <= 1'b1;
                  wb_dat_o <= {16'h0000, control_main};
               end
               `ICSF_OFF_FRAME:
               begin
                  wb_ack_o <= 1'b1;
                  wb_dat_o <= {16'h0000, frame_ctrl_status_reg};
               end
               `ICSF_OFF_EVENT:
               begin
                  wb_ack_o <= 1'b1;
                  wb_dat_o <= {9'h000, er_flags, 9'h000, ev_flags};
               end
               default: wb_err_o <= 1'b1;
            endcase
         end
      end
   end

   // control next value: software write, then hardware set/clear on top
   always_comb
   begin
      next_ctrl = control_main;
      if (wr && wb_adr_i == `ICSF_OFF_CTRL)
         next_ctrl = ((control_main & ~wmask) | (wb_dat_i[15:0] & wmask))
                     & `ICSF_CTRL_MASK;
      // crc request is spent once sent or once the frame ends
      if (crc_done_i || start_seen_i || stop_seen_i)
      begin
         next_ctrl[`ICSF_B_CRCSEND] = 1'b0;
      end
      // start request is spent when the bus shows a start
      if (start_seen_i)
      begin
         next_ctrl[`ICSF_B_START] = 1'b0;
      end
      // stop request is spent when the bus shows a stop
      if (stop_seen_i)
      begin
         next_ctrl[`ICSF_B_STOP] = 1'b0;
      end
      // a timeout forces a stop; it wins over a stop seen together
      if (error_set_i.bus_timeout)
      begin
         next_ctrl[`ICSF_B_STOP] = 1'b1;
      end
      // hardware clear of the alert request on timeout
      if (error_set_i.bus_timeout)
      begin
         next_ctrl[`ICSF_B_ALERT] = 1'b0;
      end
      // disable clears act on the value about to be stored, so a write
      // that disables and requests at once leaves only the stop and alert requests behind
      if (!next_ctrl[`ICSF_B_EN])
      begin
         next_ctrl[`ICSF_B_START] = 1'b0;
         next_ctrl[`ICSF_B_ACK] = 1'b0;
         next_ctrl[`ICSF_B_POS] = 1'b0;
         next_ctrl[`ICSF_B_CRCSEND] = 1'b0;
      end
   end

   // soft reset bit itself stays writable so software can leave reset
   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         control_main <= `ICSF_CTRL_RESET;
      end
      else
      begin
         control_main <= next_ctrl;
      end
   end

   // frame control: mode enable and interrupt enable are writable
   always_ff @(posedge clk_i)
   begin
      if (!rstn_i || soft_rst)
      begin
         frame_ctrl_status_reg <= `ICSF_FRAME_RESET;
      end
      else
      begin
         // only the two enable bits of the low lane are writable
         if (wr && wb_adr_i == `ICSF_OFF_FRAME && wb_sel_i[0])
         begin
            frame_ctrl_status_reg[`ICSF_F_MODE] <= wb_dat_i[`ICSF_F_MODE];
            frame_ctrl_status_reg[`ICSF_F_IE] <= wb_dat_i[`ICSF_F_IE];
         end
         frame_ctrl_status_reg[`ICSF_F_ILVL] <= in_sync;
         frame_ctrl_status_reg[`ICSF_F_OLVL] <= frame_out_o;
         // edge flags: write 1 clears, new edge wins over clear
         if (wr && wb_adr_i == `ICSF_OFF_FRAME && wb_sel_i[1])
         begin
            if (wb_dat_i[`ICSF_F_ORISE])
            begin
               frame_ctrl_status_reg[`ICSF_F_ORISE] <= 1'b0;
            end
            if (wb_dat_i[`ICSF_F_OFALL])
            begin
               frame_ctrl_status_reg[`ICSF_F_OFALL] <= 1'b0;
            end
            if (wb_dat_i[`ICSF_F_IRISE])
            begin
               frame_ctrl_status_reg[`ICSF_F_IRISE] <= 1'b0;
            end
            if (wb_dat_i[`ICSF_F_IFALL])
            begin
               frame_ctrl_status_reg[`ICSF_F_IFALL] <= 1'b0;
            end
         end
         // edges count only in frame mode; sets come last so they win
         if (frame_ctrl_status_reg[`ICSF_F_MODE])
         begin
            // output pin went high
            if (frame_out_o && !out_prev)
            begin
               frame_ctrl_status_reg[`ICSF_F_ORISE] <= 1'b1;
            end
            // output pin went low
            if (!frame_out_o && out_prev)
            begin
               frame_ctrl_status_reg[`ICSF_F_OFALL] <= 1'b1;
            end
            // input pin went high, seen after the synchroniser
            if (in_sync && !in_prev)
            begin
               frame_ctrl_status_reg[`ICSF_F_IRISE] <= 1'b1;
            end
            // input pin went low, seen after the synchroniser
            if (!in_sync && in_prev)
            begin
               frame_ctrl_status_reg[`ICSF_F_IFALL] <= 1'b1;
            end
         end
      end
   end

   // shared alert/frame input: two stages before any logic reads it
   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         in_meta <= 1'b1;
         in_sync <= 1'b1;
         in_prev <= 1'b1;
         out_prev <= 1'b0;
      end
      else
      begin
         in_meta <= alert_pin_i;
         in_sync <= in_meta;
         in_prev <= in_sync;
         out_prev <= frame_out_o;
      end
   end

   // frame output: busy master while frame mode and peripheral enable are on, registered
   always_ff @(posedge clk_i)
   begin
      if (!rstn_i || soft_rst)
      begin
         frame_out_o <= 1'b0;
      end
      else
      begin
         // one cycle late against busy, traded for a glitch-free pin
         frame_out_o <= frame_ctrl_status_reg[`ICSF_F_MODE]
                        && master_mode_i
                        && master_busy_i
                        && control_main[`ICSF_B_EN];
      end
   end

   // event and error flags: set wins over clear; engine clears events
   always_ff @(posedge clk_i)
   begin
      if (!rstn_i || soft_rst)
      begin
         ev_flags <= '0;
      end
      else
      begin
         ev_flags <= event_set_i | (ev_flags & ~event_clr_i);
      end
   end

   // error flags cleared by writing 1 to their bit position
   always_ff @(posedge clk_i)
   begin
      if (!rstn_i || soft_rst)
      begin
         er_flags <= '0;
      end
      else
      begin
         // a new error in the clearing cycle still lands
         if (wr && wb_adr_i == `ICSF_OFF_EVENT && wb_sel_i[2])
         begin
            er_flags <= (er_flags & ~wb_dat_i[22:16]) | error_set_i;
         end
         else
         begin
            er_flags <= er_flags | error_set_i;
         end
         // over/under has no meaning while the clock may be stretched
         if (!control_main[`ICSF_B_NOSTR])
         begin
            er_flags.over_under <= 1'b0;
         end
      end
   end

   // interrupt from any frame edge flag when enabled
   assign frame_irq_o = frame_ctrl_status_reg[`ICSF_F_IE] &&
                        |frame_ctrl_status_reg[13:10];

   // alert pin is open drain: pull low only while alert bit set
   assign alert_pin_o = 1'b0;
   assign alert_pin_oe_o = control_main[`ICSF_B_ALERT] && !soft_rst;

   // control fields steering the transfer engine
   assign ctrl_reset_o = soft_rst;
   assign periph_en_o = control_main[`ICSF_B_EN];
   assign smbus_mode_o = control_main[`ICSF_B_SMB];
   assign host_select_o = control_main[`ICSF_B_HOST];
   assign addr_res_en_o = control_main[`ICSF_B_ARP] &&
                          control_main[`ICSF_B_SMB];
   assign crc_en_o = control_main[`ICSF_B_CRC];
   assign general_call_en_o = control_main[`ICSF_B_GC];
   assign stretch_dis_o = control_main[`ICSF_B_NOSTR];
   assign start_req_o = control_main[`ICSF_B_START];
   assign stop_req_o = control_main[`ICSF_B_STOP];
   assign ack_en_o = control_main[`ICSF_B_ACK];
   assign ack_pos_o = control_main[`ICSF_B_POS];
   assign crc_send_o = control_main[`ICSF_B_CRCSEND];
endmodule : icsf_ctrl

// file: icsf_far.sv
// far-side party on the shared alert and frame input line
// assumes a pull-up on the line; any party may pull it low
`timescale 1ns/10ps
module icsf_far
(
   input wire logic link_clk_i,
   input wire logic pull_req_i,
   input wire logic dut_oe_i,
   output logic line_o
);
   logic pull = 1'b0;
   // pull moves on the link clock, out of phase with the block clock
   always_ff @(posedge link_clk_i)
   begin
      pull <= pull_req_i;
   end
   // open drain, so a released line rises to the pull-up level
   assign line_o = !(pull || dut_oe_i);
endmodule : icsf_far

// file: icsf_props.sv
// port checker for the i2c control block
// assumes binding onto icsf_ctrl, one clock domain
`timescale 1ns/10ps
module icsf_props
   import icsf_pkg::*;
(
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic wb_err_o,
   input wire logic master_busy_i,
   input wire logic master_mode_i,
   input wire icsf_error_s error_set_i,
   input wire logic crc_done_i,
   input wire logic start_seen_i,
   input wire logic stop_seen_i,
   input wire logic alert_pin_o,
   input wire logic alert_pin_oe_o,
   input wire logic frame_out_o,
   input wire logic frame_irq_o,
   input wire logic ctrl_reset_o,
   input wire logic periph_en_o,
   input wire logic start_req_o,
   input wire logic stop_req_o,
   input wire logic ack_en_o,
   input wire logic ack_pos_o,
   input wire logic crc_send_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   // no bus write can race a hardware clear
   wire quiet = !wb_stb_i && !ctrl_reset_o;
   sequence s_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   endsequence
   sequence s_busy;
      master_busy_i && master_mode_i;
   endsequence
   chk_bus_answer: assert property (s_take |=> wb_ack_o || wb_err_o)
      else $error("request not answered");
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held too long");
   chk_alert_low: assert property (alert_pin_oe_o |-> !alert_pin_o)
      else $error("alert pin not low");
   chk_start_clear: assert property (start_seen_i && quiet |=>
      !start_req_o) else $error("start not cleared");
   chk_stop_clear: assert property (stop_seen_i && quiet &&
      !error_set_i.bus_timeout |=> !stop_req_o) else $error("stop kept");
   chk_stop_set: assert property (error_set_i.bus_timeout && quiet &&
      !stop_seen_i |=> stop_req_o) else $error("stop not set");
   chk_crc_clear: assert property ((crc_done_i || start_seen_i ||
      stop_seen_i) && quiet |=> !crc_send_o) else $error("crc send kept");
   chk_off_clear: assert property (!periph_en_o |-> !(start_req_o ||
      ack_en_o || ack_pos_o || crc_send_o)) else $error("disable kept bits");
   chk_frame_cause: assert property (frame_out_o |->
      $past(master_busy_i && master_mode_i)) else $error("frame out idle");
   chk_srst_hold: assert property (ctrl_reset_o [*2] |->
      !frame_out_o && !frame_irq_o) else $error("soft reset leaks");
endmodule : icsf_props
bind icsf_ctrl icsf_props i_chk (.*);

// file: icsf_ctrl_bench.sv
// self-checking bench for the i2c control block
// assumes the far-side model and checker are compiled first
`timescale 1ns/10ps
module icsf_ctrl_bench
   import icsf_pkg::*;
;
   logic clk_i, rstn_i, wb_cyc_i, wb_we_i, lclk, pull, erq;
   logic master_busy_i, master_mode_i, wb_ack_o, wb_err_o;
   logic [3:0] wb_adr_i, wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rdq;
   logic [23:0] pv;
   logic alert_pin_o, alert_pin_oe_o, frame_out_o, frame_irq_o;
   logic ctrl_reset_o, periph_en_o, smbus_mode_o, host_select_o;
   logic addr_res_en_o, crc_en_o, general_call_en_o, stretch_dis_o;
   logic start_req_o, stop_req_o, ack_en_o, ack_pos_o, crc_send_o;
   wire alert_pin_i, crc_done_i, start_seen_i, stop_seen_i;
   wire icsf_event_s event_set_i, event_clr_i;
   wire icsf_error_s error_set_i;
   int failures = 0;
   int total_checks = 0;
   wire wb_stb_i = wb_cyc_i;
   wire [13:0] ov = {ctrl_reset_o, alert_pin_oe_o, crc_send_o, ack_pos_o,
      ack_en_o, stop_req_o, start_req_o, stretch_dis_o, general_call_en_o,
      crc_en_o, addr_res_en_o, host_select_o, smbus_mode_o, periph_en_o};
   // one pulse vector feeds every engine strobe
   assign {crc_done_i, start_seen_i, stop_seen_i, event_set_i, event_clr_i,
      error_set_i} = pv;
   icsf_ctrl i_dut (.*);
   icsf_far i_far (.link_clk_i(lclk), .pull_req_i(pull),
      .dut_oe_i(alert_pin_oe_o), .line_o(alert_pin_i));
   function automatic logic [13:0] ox(input logic [15:0] v);
      return {v[15], v[13:7], v[6:3], v[1:0]};
   endfunction : ox
   task automatic end_sim;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e)
      begin
         failures++;
         $display("wrong value at %0t: saw %h want %h", $time, s, e);
      end
   endtask : chk
   // classic cycle: held until ack or err is sampled high
   task automatic bus(input logic w, input logic [3:0] a,
      input logic [31:0] d);
      @(posedge clk_i);
      {wb_cyc_i, wb_we_i, wb_adr_i, wb_dat_i} <= {1'b1, w, a, d};
      @(posedge clk_i);
      while (!(wb_ack_o || wb_err_o))
         @(posedge clk_i);
      rdq = wb_dat_o;
      erq = wb_err_o;
      wb_cyc_i <= 1'b0;
   endtask : bus
   task automatic rdc(input logic [3:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rdq, e);
   endtask : rdc
   task automatic pls(input logic [23:0] v);
      @(posedge clk_i);
      pv <= v;
      @(posedge clk_i);
      pv <= 24'h0;
   endtask : pls
   task automatic hold(input int n);
      repeat (n) @(posedge clk_i);
   endtask : hold
   // block clock and an unrelated link clock
   initial
   begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   initial
   begin
      lclk = 1'b0;
      #7;
      forever #160 lclk = ~lclk;
   end
   // watchdog, far beyond the expected run length
   initial
   begin
      #400000;
      failures++;
      end_sim();
   end
   initial
   begin
      {rstn_i, wb_cyc_i, wb_we_i, wb_adr_i, wb_dat_i, pv, pull} = '0;
      {master_busy_i, master_mode_i, wb_sel_i} = 6'h0F;
      hold(12);
      rstn_i <= 1'b1;
      rdc(4'h0, 32'h0);
      rdc(4'h4, 32'h0200);
      chk(32'(ov), 32'h0);
      $display("reset values done");
      bus(1'b1, 4'h0, 32'hFFFF_7FFB);
      rdc(4'h0, 32'h3FFB);
      chk(32'(ov), 32'(ox(16'h3FFB)));
      bus(1'b1, 4'hC, 32'h1);
      chk(32'(erq), 32'h1);
      pls(24'h40_0000);
      rdc(4'h0, 32'h2EFB);
      pls(24'h20_0000);
      rdc(4'h0, 32'h2CFB);
      pls(24'h00_0002);
      rdc(4'h0, 32'h0EFB);
      bus(1'b1, 4'h0, 32'h1001);
      pls(24'h80_0000);
      rdc(4'h0, 32'h1);
      bus(1'b1, 4'h0, 32'h3FFA);
      rdc(4'h0, 32'h22FA);
      $display("control bits done");
      bus(1'b1, 4'h0, 32'h80);
      pls(24'h1F_C07F);
      rdc(4'h8, 32'h007F_007F);
      pls(24'h00_3F80);
      bus(1'b1, 4'h8, 32'h007F_FFFF);
      rdc(4'h8, 32'h0);
      bus(1'b1, 4'h0, 32'h0);
      pls(24'h10);
      rdc(4'h8, 32'h0);
      $display("flags done");
      master_mode_i <= 1'b1;
      bus(1'b1, 4'h0, 32'h1);
      bus(1'b1, 4'h4, 32'h3);
      master_busy_i <= 1'b1;
      hold(4);
      chk(32'(frame_out_o), 32'h1);
      rdc(4'h4, 32'h0703);
      chk(32'(frame_irq_o), 32'h1);
      master_busy_i <= 1'b0;
      hold(4);
      rdc(4'h4, 32'h0E03);
      pull <= 1'b1;
      hold(20);
      rdc(4'h4, 32'h2C03);
      pull <= 1'b0;
      hold(20);
      rdc(4'h4, 32'h3E03);
      bus(1'b1, 4'h4, 32'h3C01);
      rdc(4'h4, 32'h0201);
      chk(32'(frame_irq_o), 32'h0);
      $display("frame pins done");
      master_busy_i <= 1'b1;
      hold(4);
      bus(1'b1, 4'h0, 32'h8000);
      hold(2);
      rdc(4'h4, 32'h0);
      chk(32'(frame_out_o), 32'h0);
      chk(32'(ov), 32'(ox(16'h8000)));
      bus(1'b1, 4'h0, 32'h0);
      master_busy_i <= 1'b0;
      $display("soft reset done");
      end_sim();
   end
endmodule : icsf_ctrl_bench
